// ### verilog/wsc_regs.svh
// Offsets, field positions and figures for the shift/compare/arithmetic unit.
// Assumes a byte-addressed Avalon-MM slave port with 32-bit data.
`ifndef WSC_REGS_SVH
`define WSC_REGS_SVH
`define WSC_OFF_RES 8'h00
`define WSC_OFF_AUX 8'h04
`define WSC_OFF_OPND 8'h08
`define WSC_OFF_INSTR 8'h0C
`define WSC_OFF_STATUS 8'h10
`define WSC_OFF_STORE 8'h14
`define WSC_OFF_EADDR 8'h18
`define WSC_OFF_IDX 8'h20
`define WSC_IDX_MSB 4
`define WSC_IDX_LSB 2
`define WSC_OP_MSB 29
`define WSC_OP_LSB 24
`define WSC_J_MSB 23
`define WSC_J_LSB 21
`define WSC_K_MSB 20
`define WSC_K_LSB 18
`define WSC_B_MSB 17
`define WSC_B_LSB 15
`define WSC_Y_MSB 14
`define WSC_ST_SKIP 0
`define WSC_ST_OVF 1
`define WSC_ST_STORE 2
`define WSC_CNT_W 6
`define WSC_WORD_W 30
`define WSC_HALF_W 15
`endif

// ### verilog/wsc_pkg.sv
// Types shared by the shift/compare/arithmetic unit.
// Assumes wsc_regs.svh supplies widths.
`include "wsc_regs.svh"
package wsc_pkg;
  typedef enum logic [5:0] {
    OP_RSH_AUX = 6'h01, OP_RSH_RES = 6'h02, OP_RSH_PAIR = 6'h03, OP_CMP = 6'h04,
    OP_LSH_AUX = 6'h05, OP_LSH_RES = 6'h06, OP_LSH_PAIR = 6'h07, OP_ENT_AUX = 6'h08,
    OP_ENT_RES = 6'h09, OP_ENT_IDX = 6'h0A, OP_EXT_FN = 6'h0B, OP_STR_AUX = 6'h0C,
    OP_STR_RES = 6'h0D, OP_STR_IDX = 6'h0E, OP_STR_CHAN = 6'h0F, OP_ADD = 6'h10,
    OP_SUB = 6'h11, OP_MUL = 6'h12, OP_DIV = 6'h13
  } wsc_op_t;
  typedef logic [`WSC_WORD_W-1:0] wsc_word_t;
  typedef struct packed {
    wsc_word_t res;
    wsc_word_t aux;
    wsc_word_t opnd;
    wsc_word_t instr;
    wsc_word_t store_data;
    logic [`WSC_HALF_W-1:0] eaddr;
    logic [7:1][`WSC_HALF_W-1:0] idx;
    logic skip;
    logic ovf;
    logic store_pend;
    logic wait_req;
    logic [31:0] rdata;
    logic ef_stb;
    logic [2:0] ef_chan;
    wsc_word_t ef_word;
    logic in_ack;
    logic [2:0] in_chan;
  } wsc_state_t;
endpackage

// ### verilog/wsc_unit.sv
// Shift, compare, load/store, channel and arithmetic datapath with Avalon-MM registers.
// Assumes the sequencer forms the operand and performs memory stores from the store register.
//
// Contract
// - Right shift fills with original sign
// - Only low six operand bits count
// - Pair right shift, result low into aux
// - Compare keeps registers; field 1 always skips, 2,3 use aux
// - Compare fields 4,5 use both registers
// - Compare fields 6,7 against result register
// - Left shift rotates circularly
// - Pair left shift rotates all sixty bits
// - Enter clears then loads operand
// - Index load takes low 15 bits
// - Channels 0,1 skip on partner input active
// - Other channels send function word; k=3
// - Store aux; k0 complements, k4 copies
// - Store result; k4 complements, k0 copies
// - Index store zero-extends to 30 bits
// - Channel input stored then acknowledged
// - Add/subtract into result register
// - Multiply to pair; field 4 skip
// - Divide with overflow detection
// - Divide skip on overflow or remainder
// - Address is y plus index register
`include "wsc_regs.svh"
module wsc_unit #(
  parameter int N_CHAN = 8
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [1:0] i_ic_in_active,
  input wire logic [N_CHAN-1:0][29:0] i_chan_in_word,
  output logic o_ef_strobe,
  output logic [2:0] o_ef_chan,
  output logic [29:0] o_ef_word,
  output logic o_in_ack,
  output logic [2:0] o_in_chan
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [29:0] oc_add(input logic [29:0] a, input logic [29:0] b);
    logic [30:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[29:0] + {29'h0, s[30]};
  endfunction

  function automatic logic signed [30:0] oc_val(input logic [29:0] x);
    return x[29] ? -$signed({1'b0, ~x}) : $signed({1'b0, x});
  endfunction

  function automatic logic [28:0] oc_mag(input logic [29:0] x);
    return x[29] ? ~x[28:0] : x[28:0];
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  wsc_pkg::wsc_state_t s_r;
  wsc_pkg::wsc_state_t s_nxt;

  logic take;
  logic [31:0] wd;
  logic x_exec;
  wsc_pkg::wsc_op_t x_op;
  logic [2:0] x_j;
  logic [2:0] x_k;
  logic [5:0] x_cnt;
  logic [59:0] pair;
  logic [119:0] pair_rot;
  logic [59:0] aux_rot;
  logic [59:0] res_rot;
  logic signed [30:0] v_y;
  logic signed [30:0] v_aux;
  logic signed [30:0] v_res;
  logic [57:0] prod;
  logic [59:0] prod_pos;
  logic mul_neg;
  logic [58:0] div_mag;
  logic [28:0] div_dv;
  logic div_zero;
  logic [58:0] div_q;
  logic [58:0] div_r;
  logic div_ovf;
  logic div_neg;

  assign take = (i_avs_read | i_avs_write) & s_r.wait_req;
  assign wd = be_merge({2'h0, s_r.instr}, i_avs_writedata, i_avs_byteenable);
  assign x_exec = take & i_avs_write & (i_avs_address == `WSC_OFF_INSTR);
  assign x_op = wsc_pkg::wsc_op_t'(wd[`WSC_OP_MSB:`WSC_OP_LSB]);
  assign x_j = wd[`WSC_J_MSB:`WSC_J_LSB];
  assign x_k = wd[`WSC_K_MSB:`WSC_K_LSB];
  // Counts above 63 cannot be asked for; the upper 24 bits never reach the shifter
  assign x_cnt = s_r.opnd[`WSC_CNT_W-1:0];
  assign pair = {s_r.res, s_r.aux};
  // Doubled copies turn a circular shift into a plain one; counts wrap modulo the width
  assign pair_rot = {pair, pair} << (x_cnt % 6'd60);
  assign aux_rot = {s_r.aux, s_r.aux} << (x_cnt % 6'd30);
  assign res_rot = {s_r.res, s_r.res} << (x_cnt % 6'd30);
  assign v_y = oc_val(s_r.opnd);
  assign v_aux = oc_val(s_r.aux);
  assign v_res = oc_val(s_r.res);
  // Product built from magnitudes; sign applied afterwards
  assign prod = oc_mag(s_r.aux) * oc_mag(s_r.opnd);
  assign prod_pos = {2'h0, prod};
  assign mul_neg = s_r.aux[29] ^ s_r.opnd[29];
  assign div_mag = s_r.res[29] ? ~pair[58:0] : pair[58:0];
  assign div_dv = oc_mag(s_r.opnd);
  assign div_zero = (div_dv == 29'h0);
  // A zero divisor is replaced so the divider never sees it; the result is discarded
  assign div_q = div_mag / {30'h0, (div_zero ? 29'h1 : div_dv)};
  assign div_r = div_mag % {30'h0, (div_zero ? 29'h1 : div_dv)};
  assign div_ovf = div_zero | (div_q[58:29] != 30'h0);
  assign div_neg = s_r.res[29] ^ s_r.opnd[29];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.wait_req = 1'b1;
    s_nxt.ef_stb = 1'b0;
    s_nxt.in_ack = 1'b0;
    if (take) begin
      s_nxt.wait_req = 1'b0;
      s_nxt.rdata = 32'h0;
      if (i_avs_read) begin
        unique case (i_avs_address)
          `WSC_OFF_RES: s_nxt.rdata = {2'h0, s_r.res};
          `WSC_OFF_AUX: s_nxt.rdata = {2'h0, s_r.aux};
          `WSC_OFF_OPND: s_nxt.rdata = {2'h0, s_r.opnd};
          `WSC_OFF_INSTR: s_nxt.rdata = {2'h0, s_r.instr};
          `WSC_OFF_STATUS: s_nxt.rdata = {29'h0, s_r.store_pend, s_r.ovf, s_r.skip};
          `WSC_OFF_STORE: s_nxt.rdata = {2'h0, s_r.store_data};
          `WSC_OFF_EADDR: s_nxt.rdata = {17'h0, s_r.eaddr};
          default: begin
            if (i_avs_address[7:`WSC_IDX_MSB+1] == `WSC_OFF_IDX >> (`WSC_IDX_MSB+1) &&
                i_avs_address[1:0] == 2'h0 && i_avs_address[`WSC_IDX_MSB:`WSC_IDX_LSB] != 3'h0) begin
              s_nxt.rdata = {17'h0, s_r.idx[i_avs_address[`WSC_IDX_MSB:`WSC_IDX_LSB]]};
            end
          end
        endcase
      end else begin
        unique case (i_avs_address)
          `WSC_OFF_RES: s_nxt.res = 30'(be_merge({2'h0, s_r.res}, i_avs_writedata, i_avs_byteenable));
          `WSC_OFF_AUX: s_nxt.aux = 30'(be_merge({2'h0, s_r.aux}, i_avs_writedata, i_avs_byteenable));
          `WSC_OFF_OPND: s_nxt.opnd = 30'(be_merge({2'h0, s_r.opnd}, i_avs_writedata, i_avs_byteenable));
          `WSC_OFF_STATUS: begin
            if (i_avs_byteenable[0] && i_avs_writedata[`WSC_ST_STORE]) begin
              s_nxt.store_pend = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
    if (x_exec) begin
      s_nxt.instr = wd[29:0];
      s_nxt.skip = 1'b0;
      s_nxt.eaddr = wd[`WSC_Y_MSB:0] + ((wd[`WSC_B_MSB:`WSC_B_LSB] == 3'h0) ? 15'h0 :
                    s_r.idx[wd[`WSC_B_MSB:`WSC_B_LSB]]);
      unique case (x_op)
        wsc_pkg::OP_RSH_AUX: s_nxt.aux = $signed(s_r.aux) >>> x_cnt;
        wsc_pkg::OP_RSH_RES: s_nxt.res = $signed(s_r.res) >>> x_cnt;
        wsc_pkg::OP_RSH_PAIR: {s_nxt.res, s_nxt.aux} = $signed(pair) >>> x_cnt;
        wsc_pkg::OP_CMP: begin
          unique case (x_j)
            3'h0: s_nxt.skip = 1'b0;
            3'h1: s_nxt.skip = 1'b1;
            3'h2: s_nxt.skip = v_y <= v_aux;
            3'h3: s_nxt.skip = v_y > v_aux;
            3'h4: s_nxt.skip = (v_aux >= v_y) && (v_y > v_res);
            3'h5: s_nxt.skip = (v_y > v_aux) || (v_y <= v_res);
            3'h6: s_nxt.skip = v_y <= v_res;
            3'h7: s_nxt.skip = v_y > v_res;
          endcase
        end
        wsc_pkg::OP_LSH_AUX: s_nxt.aux = aux_rot[59:30];
        wsc_pkg::OP_LSH_RES: s_nxt.res = res_rot[59:30];
        wsc_pkg::OP_LSH_PAIR: {s_nxt.res, s_nxt.aux} = pair_rot[119:60];
        wsc_pkg::OP_ENT_AUX: s_nxt.aux = s_r.opnd;
        wsc_pkg::OP_ENT_RES: s_nxt.res = s_r.opnd;
        wsc_pkg::OP_ENT_IDX: begin
          if (x_j != 3'h0) begin
            s_nxt.idx[x_j] = s_r.opnd[`WSC_HALF_W-1:0];
          end
        end
        wsc_pkg::OP_EXT_FN: begin
          if (x_j[2:1] == 2'h0) begin
            s_nxt.skip = i_ic_in_active[x_j[0]];
          end else begin
            s_nxt.ef_stb = 1'b1;
            s_nxt.ef_chan = x_j;
            s_nxt.ef_word = s_r.opnd;
          end
        end
        wsc_pkg::OP_STR_AUX: begin
          if (x_k == 3'h0) begin
            s_nxt.aux = ~s_r.aux;
          end else if (x_k == 3'h4) begin
            s_nxt.res = s_r.aux;
          end else begin
            s_nxt.store_data = s_r.aux;
            s_nxt.store_pend = 1'b1;
          end
        end
        wsc_pkg::OP_STR_RES: begin
          if (x_k == 3'h4) begin
            s_nxt.res = ~s_r.res;
          end else if (x_k == 3'h0) begin
            s_nxt.aux = s_r.res;
          end else begin
            s_nxt.store_data = s_r.res;
            s_nxt.store_pend = 1'b1;
          end
        end
        wsc_pkg::OP_STR_IDX: begin
          s_nxt.store_data = {15'h0, (x_j == 3'h0) ? 15'h0 : s_r.idx[x_j]};
          s_nxt.store_pend = 1'b1;
        end
        wsc_pkg::OP_STR_CHAN: begin
          // No synchronisation with buffer transfers: the sequencer must space these out
          s_nxt.store_data = (32'(x_j) < N_CHAN) ? i_chan_in_word[x_j] : 30'h0;
          s_nxt.store_pend = 1'b1;
          s_nxt.in_ack = 1'b1;
          s_nxt.in_chan = x_j;
        end
        wsc_pkg::OP_ADD: s_nxt.res = oc_add(s_r.res, s_r.opnd);
        wsc_pkg::OP_SUB: s_nxt.res = oc_add(s_r.res, ~s_r.opnd);
        wsc_pkg::OP_MUL: begin
          {s_nxt.res, s_nxt.aux} = mul_neg ? ~prod_pos : prod_pos;
          s_nxt.skip = (x_j == 3'h1) || ((x_j == 3'h4) && (prod_pos[59:30] == 30'h0));
        end
        wsc_pkg::OP_DIV: begin
          s_nxt.ovf = div_ovf;
          if (!div_ovf) begin
            s_nxt.aux = div_neg ? ~{1'b0, div_q[28:0]} : {1'b0, div_q[28:0]};
            s_nxt.res = div_neg ? ~{1'b0, div_r[28:0]} : {1'b0, div_r[28:0]};
          end
          unique case (x_j)
            3'h1: s_nxt.skip = 1'b1;
            3'h2: s_nxt.skip = !div_ovf;
            3'h3: s_nxt.skip = div_ovf;
            3'h4: s_nxt.skip = div_ovf ? (oc_mag(s_r.res) == 29'h0) : (div_r[28:0] == 29'h0);
            3'h5: s_nxt.skip = div_ovf ? (oc_mag(s_r.res) != 29'h0) : (div_r[28:0] != 29'h0);
            default: s_nxt.skip = 1'b0;
          endcase
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      s_r <= '0;
      s_r.wait_req <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_avs_readdata = s_r.rdata;
  assign o_avs_waitrequest = s_r.wait_req;
  assign o_ef_strobe = s_r.ef_stb;
  assign o_ef_chan = s_r.ef_chan;
  assign o_ef_word = s_r.ef_word;
  assign o_in_ack = s_r.in_ack;
  assign o_in_chan = s_r.in_chan;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  property p_rsh_sign;
    x_exec && x_op == wsc_pkg::OP_RSH_RES && x_cnt != 6'h0 |=> s_r.res[29:28] == {2{$past(s_r.res[29])}};
  endproperty
  a_rsh_sign: assert property (p_rsh_sign) else $error("right shift lost the sign fill");

  property p_cnt_low;
    x_exec && x_op == wsc_pkg::OP_RSH_AUX && x_cnt == 6'h0 |=> s_r.aux == $past(s_r.aux);
  endproperty
  a_cnt_low: assert property (p_cnt_low) else $error("upper operand bits changed the shift");

  property p_pair_rsh;
    x_exec && x_op == wsc_pkg::OP_RSH_PAIR && x_cnt == 6'd30 |=>
      s_r.aux == $past(s_r.res) && s_r.res == {30{$past(s_r.res[29])}};
  endproperty
  a_pair_rsh: assert property (p_pair_rsh) else $error("pair right shift moved wrong bits");

  property p_cmp_keep;
    x_exec && x_op == wsc_pkg::OP_CMP |=> s_r.aux == $past(s_r.aux) && s_r.res == $past(s_r.res) ##1 s_r.wait_req;
  endproperty
  a_cmp_keep: assert property (p_cmp_keep) else $error("compare altered a register");

  property p_cmp_j6;
    x_exec && x_op == wsc_pkg::OP_CMP && x_j == 3'h6 && s_r.opnd == s_r.res |=> s_r.skip;
  endproperty
  a_cmp_j6: assert property (p_cmp_j6) else $error("equal compare did not skip");

  property p_lsh_full;
    x_exec && x_op == wsc_pkg::OP_LSH_PAIR && x_cnt == 6'd30 |=>
      s_r.res == $past(s_r.aux) && s_r.aux == $past(s_r.res);
  endproperty
  a_lsh_full: assert property (p_lsh_full) else $error("pair rotate by half did not swap");

  property p_lsh_word;
    x_exec && x_op == wsc_pkg::OP_LSH_AUX && x_cnt == 6'h1 |=> s_r.aux == {$past(s_r.aux[28:0]), $past(s_r.aux[29])};
  endproperty
  a_lsh_word: assert property (p_lsh_word) else $error("rotate by one wrong");

  property p_enter;
    x_exec && x_op == wsc_pkg::OP_ENT_RES |=> s_r.res == $past(s_r.opnd);
  endproperty
  a_enter: assert property (p_enter) else $error("enter did not load the operand");

  property p_idx_load;
    x_exec && x_op == wsc_pkg::OP_ENT_IDX && x_j != 3'h0 |=>
      s_r.idx[$past(x_j)] == $past(s_r.opnd[`WSC_HALF_W-1:0]);
  endproperty
  a_idx_load: assert property (p_idx_load) else $error("index load took the wrong bits");

  property p_skip_ic;
    x_exec && x_op == wsc_pkg::OP_EXT_FN && x_j[2:1] == 2'h0 |=>
      s_r.skip == $past(i_ic_in_active[x_j[0]]) && !o_ef_strobe;
  endproperty
  a_skip_ic: assert property (p_skip_ic) else $error("partner input flag not sampled into skip");

  property p_ef_send;
    x_exec && x_op == wsc_pkg::OP_EXT_FN && x_j[2:1] != 2'h0 |=>
      o_ef_strobe && o_ef_word == $past(s_r.opnd) && o_ef_chan == $past(x_j) ##1 !o_ef_strobe;
  endproperty
  a_ef_send: assert property (p_ef_send) else $error("function word not sent as one pulse");

  property p_idx_store;
    x_exec && x_op == wsc_pkg::OP_STR_IDX |=> s_r.store_pend && s_r.store_data[29:15] == 15'h0;
  endproperty
  a_idx_store: assert property (p_idx_store) else $error("index store high half not zero");

  property p_in_ack;
    x_exec && x_op == wsc_pkg::OP_STR_CHAN |=> o_in_ack && s_r.store_pend ##1 !o_in_ack;
  endproperty
  a_in_ack: assert property (p_in_ack) else $error("input acknowledge not a single pulse");

  property p_div_zero;
    x_exec && x_op == wsc_pkg::OP_DIV && div_zero |=> s_r.ovf && s_r.aux == $past(s_r.aux);
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("zero divisor without overflow");

  property p_bus_answer;
    (i_avs_read || i_avs_write) && s_r.wait_req |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("waitrequest not one cycle low");

  c_cmp_skip: cover property (x_exec && x_op == wsc_pkg::OP_CMP ##1 s_r.skip);
  c_div_ovf: cover property (x_exec && x_op == wsc_pkg::OP_DIV ##1 s_r.ovf);
  c_mul_skip: cover property (x_exec && x_op == wsc_pkg::OP_MUL && x_j == 3'h4 ##1 s_r.skip);
  c_ef: cover property (o_ef_strobe);
  c_lsh_pair: cover property (x_exec && x_op == wsc_pkg::OP_LSH_PAIR);

endmodule

// ### testbench/wsc_far_model.sv
// Far-side stand-in: interconnected computer flags and input channel words.
// Assumes the unit pulses function strobe and input acknowledge for one cycle each.
module wsc_far_model (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [1:0] i_busy,
  input wire logic i_ef_strobe,
  input wire logic i_in_ack,
  input wire logic [2:0] i_in_chan,
  output logic [1:0] o_ic_in_active,
  output logic [7:0][29:0] o_chan_in_word,
  output logic [7:0] o_ef_count,
  output logic [7:0] o_ack_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0][7:0] seq_r;
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_ic_in_active <= 2'h0;
      o_ef_count <= 8'h00;
      o_ack_count <= 8'h00;
      seq_r <= '0;
    end else begin
      o_ic_in_active <= i_busy;
      o_ef_count <= o_ef_count + 8'(i_ef_strobe);
      if (i_in_ack) begin
        o_ack_count <= o_ack_count + 8'h01;
        seq_r[i_in_chan] <= seq_r[i_in_chan] + 8'h01;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // New word after each acknowledge, so a late capture reads the next word
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      o_chan_in_word[c] = {seq_r[c], 19'h2B3C5, 3'(c)};
    end
  end
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the shift/compare/arithmetic unit.
// Assumes the unit answers every request by lowering waitrequest; no latency is assumed.
`include "wsc_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [1:0] busy = 2'h0;
  logic [31:0] rdata;
  logic wreq, efs, ack;
  logic [1:0] act;
  logic [7:0][29:0] cw;
  logic [2:0] efc, ackc;
  logic [29:0] efw;
  logic [7:0] ef_n, ack_n;
  logic [31:0] rnd = 32'h25;
  int num_errors = 0;
  int comparisons = 0;
  localparam logic [5:0] SOP [6] = '{6'h01, 6'h02, 6'h03, 6'h05, 6'h06, 6'h07};
  localparam logic [2:0] KT [6] = '{3'h3, 3'h0, 3'h4, 3'h4, 3'h0, 3'h3};
  // Columns: op, j, A, Q, operand, expected A, expected Q, expected status
  localparam logic [29:0] MD [8][8] = '{
    '{30'h12, 30'h4, 30'h0, 30'h3, 30'h5, 30'h0, 30'hF, 30'h1},
    '{30'h12, 30'h4, 30'h0, 30'h10000000, 30'h8, 30'h2, 30'h0, 30'h0},
    '{30'h13, 30'h5, 30'h0, 30'h64, 30'h7, 30'h2, 30'hE, 30'h1},
    '{30'h13, 30'h4, 30'h0, 30'h62, 30'h7, 30'h0, 30'hE, 30'h1},
    '{30'h13, 30'h2, 30'h0, 30'h62, 30'h7, 30'h0, 30'hE, 30'h1},
    '{30'h13, 30'h3, 30'h0, 30'h62, 30'h0, 30'h0, 30'h62, 30'h3},
    '{30'h13, 30'h2, 30'h0, 30'h62, 30'h3FFFFFFF, 30'h0, 30'h62, 30'h2},
    '{30'h13, 30'h3, 30'h1, 30'h0, 30'h1, 30'h1, 30'h0, 30'h3}};
  always #10 i_clock = ~i_clock;
  wsc_unit #(.N_CHAN(8)) dut (.i_clock(i_clock), .i_srst(i_srst), .i_avs_address(adr), .i_avs_read(rd_q),
    .i_avs_write(wr_q), .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_ic_in_active(act), .i_chan_in_word(cw), .o_ef_strobe(efs), .o_ef_chan(efc),
    .o_ef_word(efw), .o_in_ack(ack), .o_in_chan(ackc));
  wsc_far_model far (.i_clock(i_clock), .i_srst(i_srst), .i_busy(busy), .i_ef_strobe(efs), .i_in_ack(ack),
    .i_in_chan(ackc), .o_ic_in_active(act), .o_chan_in_word(cw), .o_ef_count(ef_n), .o_ack_count(ack_n));
  ////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is sampled low at a rising edge; data taken and request dropped there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clock);
    adr <= a;
    wr_q <= w;
    rd_q <= ~w;
    wd <= d;
    do begin
      @(posedge i_clock);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (wreq !== 1'b0) begin
      num_errors++;
      finish_test();
    end
    q = rdata;
    wr_q <= 1'b0;
    rd_q <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, a, d, t);
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  task automatic exec(input logic [5:0] op, input logic [2:0] j, k, b, input logic [14:0] y, input logic [29:0] d);
    wr(`WSC_OFF_OPND, {2'b0, d});
    wr(`WSC_OFF_INSTR, {2'b0, op, j, k, b, y});
  endtask
  task automatic ld(input logic [29:0] a, q);
    exec(wsc_pkg::OP_ENT_RES, 3'h0, 3'h3, 3'h0, 15'h0, a);
    exec(wsc_pkg::OP_ENT_AUX, 3'h0, 3'h3, 3'h0, 15'h0, q);
  endtask
  task automatic regs(input logic [29:0] ea, eq);
    logic [31:0] t;
    rdr(`WSC_OFF_RES, t);
    chk(t, {2'b0, ea});
    rdr(`WSC_OFF_AUX, t);
    chk(t, {2'b0, eq});
  endtask
  task automatic pick(output logic [29:0] v);
    for (int i = 0; i < 7; i++) begin
      rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    end
    v = rnd[29:0];
  endtask
  ////////////////////////////////////////////////////////////////
  function automatic longint oval(input logic [29:0] w);
    logic [29:0] c;
    c = ~w;
    return w[29] ? -longint'(c) : longint'(w);
  endfunction
  function automatic logic [29:0] oadd(input logic [29:0] a, b);
    logic [30:0] s;
    s = a + b;
    return s[29:0] + s[30];
  endfunction
  function automatic logic [59:0] shx(input logic [5:0] op, input logic [29:0] a, q, input logic [5:0] n);
    logic [119:0] u, u2;
    logic [59:0] v, r;
    logic [29:0] s;
    r = {a, q};
    s = op[0] ? q : a;
    u = {{90{s[29]}}, s} >> n;
    v = {s, s} << (n % 30);
    case (op)
      6'h01: r[29:0] = u[29:0];
      6'h02: r[59:30] = u[29:0];
      6'h05: r[29:0] = v[59:30];
      6'h06: r[59:30] = v[59:30];
      6'h03: begin
        u2 = {{60{a[29]}}, a, q} >> n;
        r = u2[59:0];
      end
      default: begin
        u2 = {a, q, a, q} << (n % 60);
        r = u2[119:60];
      end
    endcase
    return r;
  endfunction
  function automatic logic [31:0] cskip(input logic [2:0] j, input logic [29:0] a, q, y);
    longint va, vq, vy;
    logic b;
    va = oval(a);
    vq = oval(q);
    vy = oval(y);
    case (j)
      3'h0: b = 1'b0;
      3'h1: b = 1'b1;
      3'h2: b = vy <= vq;
      3'h3: b = vy > vq;
      3'h4: b = vq >= vy && vy > va;
      3'h5: b = vy > vq || vy <= va;
      3'h6: b = vy <= va;
      default: b = vy > va;
    endcase
    return {31'h0, b};
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] t, u;
    logic [29:0] a, q, y, ea, eq;
    logic [59:0] p;
    logic [5:0] n, op;
    logic [2:0] k;
    int i;
    repeat (10) @(posedge i_clock);
    i_srst <= 1'b0;
    for (i = 0; i < 24; i++) begin
      pick(a);
      pick(q);
      pick(y);
      op = SOP[i % 6];
      n = (i < 6) ? {6{i[0]}} : y[5:0];
      if (op > 6'h04) n = n % 60;
      y[5:0] = n;
      ld(a, q);
      exec(op, 3'h0, 3'h3, 3'h0, y[14:0], y);
      p = shx(op, a, q, n);
      regs(p[59:30], p[29:0]);
    end
    $display("test shift done");
    for (i = 0; i < 24; i++) begin
      pick(a);
      pick(q);
      pick(y);
      if (i[3]) y = q;
      if (i[4]) y = a;
      ld(a, q);
      exec(wsc_pkg::OP_CMP, i[2:0], 3'h3, 3'h0, y[14:0], y);
      rdr(`WSC_OFF_STATUS, t);
      chk(t & 32'h1, cskip(i[2:0], a, q, y));
      regs(a, q);
    end
    $display("test compare done");
    for (i = 1; i < 8; i++) begin
      pick(y);
      pick(a);
      exec(wsc_pkg::OP_ENT_IDX, i[2:0], 3'h3, 3'h0, y[14:0], y);
      rdr(`WSC_OFF_IDX + 8'(4 * i), t);
      chk(t, {17'h0, y[14:0]});
      exec(wsc_pkg::OP_STR_IDX, i[2:0], 3'h3, i[2:0], a[14:0], a);
      rdr(`WSC_OFF_STORE, t);
      chk(t, {17'h0, y[14:0]});
      rdr(`WSC_OFF_EADDR, t);
      chk(t, {17'h0, 15'(a[14:0] + y[14:0])});
      rdr(`WSC_OFF_STATUS, t);
      chk(t & 32'h4, 32'h4);
      wr(`WSC_OFF_STATUS, 32'h4);
    end
    rdr(`WSC_OFF_STATUS, t);
    chk(t & 32'h4, 32'h0);
    rdr(8'h1C, t);
    chk(t, 32'h0);
    rdr(`WSC_OFF_IDX, t);
    chk(t, 32'h0);
    $display("test index done");
    for (i = 0; i < 6; i++) begin
      pick(a);
      pick(q);
      k = KT[i];
      op = (i < 3) ? wsc_pkg::OP_STR_AUX : wsc_pkg::OP_STR_RES;
      ea = (i < 3 && k == 3'h4) ? q : (i >= 3 && k == 3'h4) ? ~a : a;
      eq = (i < 3 && k == 3'h0) ? ~q : (i >= 3 && k == 3'h0) ? a : q;
      ld(a, q);
      exec(op, 3'h0, k, 3'h0, 15'h0, 30'h0);
      regs(ea, eq);
      rdr(`WSC_OFF_STORE, t);
      if (k == 3'h3) chk(t, {2'b0, (i < 3) ? q : a});
    end
    $display("test store done");
    for (i = 0; i < 8; i++) begin
      pick(a);
      pick(y);
      if (i < 2) a = 30'h3FFFFFFE;
      if (i < 2) y = {29'h0, ~i[0]} | {30{i[0]}};
      ld(a, y);
      exec(i[0] ? wsc_pkg::OP_SUB : wsc_pkg::OP_ADD, 3'h0, 3'h3, 3'h0, y[14:0], y);
      rdr(`WSC_OFF_RES, t);
      chk(t, {2'b0, oadd(a, i[0] ? ~y : y)});
    end
    $display("test add done");
    for (i = 0; i < 8; i++) begin
      ld(MD[i][2], MD[i][3]);
      exec(MD[i][0][5:0], MD[i][1][2:0], 3'h3, 3'h0, MD[i][4][14:0], MD[i][4]);
      regs(MD[i][5], MD[i][6]);
      rdr(`WSC_OFF_STATUS, t);
      chk(t & 32'h3, {2'b0, MD[i][7]});
    end
    $display("test multiply divide done");
    for (i = 0; i < 8; i++) begin
      pick(y);
      busy <= y[1:0];
      u = {24'h0, ef_n};
      exec(wsc_pkg::OP_EXT_FN, i[2:0], 3'h3, 3'h0, y[14:0], y);
      rdr(`WSC_OFF_STATUS, t);
      if (i < 2) chk(t & 32'h1, {31'h0, y[i]});
      chk({24'h0, ef_n}, u + ((i < 2) ? 0 : 1));
      if (i >= 2) chk({2'b0, efw}, {2'b0, y});
      if (i >= 2) chk({29'h0, efc}, i);
    end
    $display("test function done");
    for (i = 0; i < 8; i++) begin
      a = cw[i];
      u = {24'h0, ack_n};
      exec(wsc_pkg::OP_STR_CHAN, i[2:0], 3'h3, 3'h0, 15'h0, 30'h0);
      rdr(`WSC_OFF_STORE, t);
      chk(t, {2'b0, a});
      chk({24'h0, ack_n}, u + 1);
      chk({29'h0, ackc}, i);
    end
    $display("test channel done");
    finish_test();
  end
endmodule
